// *** slr_lun_router.sv ***
// command router for scc lun addressing and fault indicator
`timescale 1ns/1ps
`default_nettype none
// Operation
// - in scc mode, method 00 sends the command to the internal processor.
// - in scc mode, method 10 routes to the encoded bus, target and lun.
// - inquiry by peripheral method reports device type controller, code 0xC.
// - report luns by peripheral method is passed to the processor and flagged on proc_report_luns.
// - fault indicator on in self test, off in normal use, on for faults.
// - only the first two lun bytes are decoded for the address; all eight are checked for zero.
// - inquiry to the device itself answered only when all eight lun bytes are zero.
module slr_lun_router #(
    parameter int unsigned SELFTEST_CYCLES = slr_pkg::selftest_cycles
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scc_mode,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [63:0] cmd_lun,
    input wire logic comp_fault,
    output logic proc_valid,
    output logic [7:0] proc_opcode,
    output logic proc_inquiry,
    output logic [4:0] proc_pdt,
    output logic proc_report_luns,
    output logic route_valid,
    output logic [2:0] route_bus,
    output logic [5:0] route_target,
    output logic [4:0] route_lun,
    output logic reject_valid,
    output logic ready,
    output logic fault_led
);
    initial begin
        if (SELFTEST_CYCLES < 1 || SELFTEST_CYCLES > 65535) begin
            $error("SELFTEST_CYCLES out of range");
        end
    end

    slr_dec_if dec_c ();
    slr_lun_decode u_dec (
        .lun_field(cmd_lun),
        .dec(dec_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // command dispatch
    slr_pkg::slr_dest_type dest;
    logic proc_valid_d, proc_valid_q;
    logic [7:0] proc_opcode_d, proc_opcode_q;
    logic proc_inq_d, proc_inq_q;
    logic [4:0] proc_pdt_d, proc_pdt_q;
    logic proc_rl_d, proc_rl_q;
    logic route_valid_d, route_valid_q;
    logic [2:0] route_bus_d, route_bus_q;
    logic [5:0] route_target_d, route_target_q;
    logic [4:0] route_lun_d, route_lun_q;
    logic reject_d, reject_q;
    logic accept;

    assign accept = cmd_valid && ready;

    always_comb begin
        dest = slr_pkg::slr_dest_none_type;
        if (accept) begin
            if (!scc_mode) begin
                dest = slr_pkg::slr_dest_ignore_type;
            end else begin
                case (dec_c.method)
                    slr_pkg::am_periph: begin
                        // inquiry to the device needs an all-zero lun
                        if (cmd_opcode == slr_pkg::op_inquiry && !dec_c.lun_all_zero) begin
                            dest = slr_pkg::slr_dest_reject_type;
                        end else begin
                            dest = slr_pkg::slr_dest_proc_type;
                        end
                    end
                    slr_pkg::am_logical: dest = slr_pkg::slr_dest_route_type;
                    slr_pkg::am_volume: dest = slr_pkg::slr_dest_reject_type;
                    slr_pkg::am_reserved: dest = slr_pkg::slr_dest_reject_type;
                    default: dest = slr_pkg::slr_dest_reject_type;
                endcase
            end
        end
    end

    always_comb begin
        proc_valid_d = (dest == slr_pkg::slr_dest_proc_type);
        proc_opcode_d = proc_opcode_q;
        proc_inq_d = 1'b0;
        proc_pdt_d = proc_pdt_q;
        proc_rl_d = 1'b0;
        route_valid_d = (dest == slr_pkg::slr_dest_route_type);
        route_bus_d = route_bus_q;
        route_target_d = route_target_q;
        route_lun_d = route_lun_q;
        reject_d = (dest == slr_pkg::slr_dest_reject_type);
        if (dest == slr_pkg::slr_dest_proc_type) begin
            proc_opcode_d = cmd_opcode;
            proc_inq_d = (cmd_opcode == slr_pkg::op_inquiry);
            proc_pdt_d = slr_pkg::pdt_controller;
            proc_rl_d = (cmd_opcode == slr_pkg::op_report_luns);
        end
        if (dest == slr_pkg::slr_dest_route_type) begin
            route_bus_d = dec_c.bus;
            route_target_d = dec_c.target;
            route_lun_d = dec_c.lun;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            proc_valid_q <= 1'b0;
            proc_opcode_q <= 8'h00;
            proc_inq_q <= 1'b0;
            proc_pdt_q <= 5'h00;
            proc_rl_q <= 1'b0;
            route_valid_q <= 1'b0;
            route_bus_q <= 3'h0;
            route_target_q <= 6'h00;
            route_lun_q <= 5'h00;
            reject_q <= 1'b0;
        end else begin
            proc_valid_q <= proc_valid_d;
            proc_opcode_q <= proc_opcode_d;
            proc_inq_q <= proc_inq_d;
            proc_pdt_q <= proc_pdt_d;
            proc_rl_q <= proc_rl_d;
            route_valid_q <= route_valid_d;
            route_bus_q <= route_bus_d;
            route_target_q <= route_target_d;
            route_lun_q <= route_lun_d;
            reject_q <= reject_d;
        end
    end

    assign proc_valid = proc_valid_q;
    assign proc_opcode = proc_opcode_q;
    assign proc_inquiry = proc_inq_q;
    assign proc_pdt = proc_pdt_q;
    assign proc_report_luns = proc_rl_q;
    assign route_valid = route_valid_q;
    assign route_bus = route_bus_q;
    assign route_target = route_target_q;
    assign route_lun = route_lun_q;
    assign reject_valid = reject_q;

    ////////////////////////////////////////////////////////////////////////
    // self test and fault indicator
    slr_pkg::slr_state_type st_d, st_q;
    logic [15:0] cnt_d, cnt_q;
    logic led_d, led_q;
    logic ready_d, ready_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            slr_pkg::slr_st_selftest_type: begin
                if (cnt_q == 16'(SELFTEST_CYCLES - 1)) begin
                    st_d = comp_fault ? slr_pkg::slr_st_fault_type : slr_pkg::slr_st_run_type;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            slr_pkg::slr_st_run_type: begin
                if (comp_fault) begin
                    st_d = slr_pkg::slr_st_fault_type;
                end
            end
            slr_pkg::slr_st_fault_type: begin
                if (!comp_fault) begin
                    st_d = slr_pkg::slr_st_run_type;
                end
            end
            default: st_d = slr_pkg::slr_st_selftest_type;
        endcase
        led_d = (st_d != slr_pkg::slr_st_run_type);
        ready_d = (st_d != slr_pkg::slr_st_selftest_type);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= slr_pkg::slr_st_selftest_type;
            cnt_q <= 16'h0000;
            led_q <= 1'b1;
            ready_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            led_q <= led_d;
            ready_q <= ready_d;
        end
    end

    assign fault_led = led_q;
    assign ready = ready_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_periph_cmd;
        accept && scc_mode && dec_c.method == slr_pkg::am_periph && cmd_opcode != slr_pkg::op_inquiry;
    endsequence

    AST_PERIPH_TO_PROC: assert property (@(posedge mclk) disable iff (!rst_b)
        s_periph_cmd |=> proc_valid && !route_valid && !reject_valid)
        else $error("peripheral command not sent to processor");
    AST_LOGICAL_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
        accept && scc_mode && dec_c.method == slr_pkg::am_logical
        |=> route_valid && route_bus == $past(cmd_lun[55:53]) && route_target == $past(cmd_lun[61:56]))
        else $error("logical unit command routed wrong");
    AST_INQ_PDT: assert property (@(posedge mclk) disable iff (!rst_b)
        proc_inquiry |-> proc_valid && proc_pdt == slr_pkg::pdt_controller)
        else $error("inquiry not reported as controller");
    AST_REPORT_LUNS: assert property (@(posedge mclk) disable iff (!rst_b)
        s_periph_cmd and cmd_opcode == slr_pkg::op_report_luns |=> proc_report_luns)
        else $error("report luns not flagged");
    AST_LED_RUN: assert property (@(posedge mclk) disable iff (!rst_b)
        ready && !comp_fault |=> !fault_led)
        else $error("fault led on without fault");
    AST_LED_SELFTEST: assert property (@(posedge mclk) disable iff (!rst_b)
        !ready |-> fault_led)
        else $error("fault led off during self test");
    AST_LOW_BYTES: assert property (@(posedge mclk) disable iff (!rst_b)
        accept && scc_mode && cmd_lun[63:62] == slr_pkg::am_logical |=> route_valid)
        else $error("lower lun bytes affected decode");
    AST_INQ_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        accept && scc_mode && dec_c.method == slr_pkg::am_periph
        && cmd_opcode == slr_pkg::op_inquiry && cmd_lun != 64'h0000_0000_0000_0000
        |=> !proc_valid && reject_valid)
        else $error("inquiry answered with nonzero lun");
    AST_REJECT: assert property (@(posedge mclk) disable iff (!rst_b)
        accept && scc_mode && dec_c.method[0] |=> reject_valid ##1 !reject_valid || $past(accept))
        else $error("volume or reserved method not rejected");
endmodule // slr_lun_router
`default_nettype wire

// *** slr_pkg.sv ***
// constants and types shared by the lun router
package slr_pkg;
    localparam int unsigned clk_period_ns = 50;
    localparam int unsigned opcode_w = 8;
    localparam logic [7:0] op_inquiry = 8'h12;
    localparam logic [7:0] op_report_luns = 8'hA0;
    localparam logic [1:0] am_periph = 2'b00;
    localparam logic [1:0] am_volume = 2'b01;
    localparam logic [1:0] am_logical = 2'b10;
    localparam logic [1:0] am_reserved = 2'b11;
    localparam logic [4:0] pdt_controller = 5'h0C;
    localparam int unsigned am_hi = 7;
    localparam int unsigned am_lo = 6;
    localparam int unsigned lu_target_w = 6;
    localparam int unsigned lu_bus_w = 3;
    localparam int unsigned lu_lun_w = 5;
    localparam int unsigned lun_bytes = 8;
    localparam int unsigned lun_used_bytes = 2;
    localparam int unsigned selftest_cycles = 16;
    typedef enum logic [2:0] {
        slr_dest_none_type = 3'b000,
        slr_dest_proc_type = 3'b001,
        slr_dest_route_type = 3'b010,
        slr_dest_reject_type = 3'b011,
        slr_dest_ignore_type = 3'b100
    } slr_dest_type;
    typedef enum logic [1:0] {
        slr_st_selftest_type = 2'b00,
        slr_st_run_type = 2'b01,
        slr_st_fault_type = 2'b10
    } slr_state_type;
endpackage

// *** slr_dec_if.sv ***
// decode result carried from the lun decoder to the router core
`timescale 1ns/1ps
`default_nettype none
interface slr_dec_if;
    logic [1:0] method;
    logic lun_all_zero;
    logic [5:0] target;
    logic [2:0] bus;
    logic [4:0] lun;
    logic [5:0] periph_bus;
    logic [7:0] periph_tl;
    modport dec (output method, lun_all_zero, target, bus, lun, periph_bus, periph_tl);
    modport core (input method, lun_all_zero, target, bus, lun, periph_bus, periph_tl);
endinterface
`default_nettype wire

// *** slr_lun_decode.sv ***
// combinational decoder of the fcp lun field
`timescale 1ns/1ps
`default_nettype none
module slr_lun_decode (
    input wire logic [63:0] lun_field,
    slr_dec_if.dec dec
);
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [slr_pkg::lun_bytes-1:0] byte_zero;

    // only first-level addressing: bytes 0 and 1 carry the address
    assign byte0 = lun_field[63:56];
    assign byte1 = lun_field[55:48];

    genvar g;
    generate
        for (g = 0; g < slr_pkg::lun_bytes; g++) begin : g_zero
            assign byte_zero[g] = (lun_field[g*8 +: 8] == 8'h00);
        end
    endgenerate

    assign dec.lun_all_zero = &byte_zero;
    assign dec.method = byte0[slr_pkg::am_hi:slr_pkg::am_lo];
    assign dec.target = byte0[5:0];
    assign dec.bus = byte1[7:5];
    assign dec.lun = byte1[4:0];
    assign dec.periph_bus = byte0[5:0];
    assign dec.periph_tl = byte1;
endmodule // slr_lun_decode
`default_nettype wire

// *** slr_host.sv ***
// initiator model that issues fcp commands to the lun router
`timescale 1ns/1ps
`default_nettype none
module slr_host (
    input wire logic mclk,
    input wire logic ready,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [63:0] cmd_lun
);
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h5A;
        cmd_lun = 64'hA5A5_5A5A_C3C3_3C3C;
    end
    // hold the command until an edge finds ready high; no release so calls run back to back
    // a ready that never comes is caught by the bench cycle ceiling
    task automatic send(logic [7:0] op, logic [63:0] lun);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_lun = lun;
        @(posedge mclk);
        while (!ready) begin
            @(posedge mclk);
        end
        #1;
    endtask
    // released lines show the inverse of the last value, never a stale copy
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_opcode = ~cmd_opcode;
        cmd_lun = ~cmd_lun;
    endtask
endmodule // slr_host
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the lun router
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int st = 4;
    logic mclk, rst_b, scc_mode, comp_fault, cmd_valid;
    logic [7:0] cmd_opcode, proc_opcode, e_op, op;
    logic [63:0] cmd_lun, e_lun, lun;
    logic proc_valid, proc_inquiry, proc_report_luns, route_valid, reject_valid, ready, fault_led;
    logic [4:0] proc_pdt, route_lun;
    logic [2:0] route_bus;
    logic [5:0] route_target;
    logic f_prev = 1'b0;
    logic r_prev = 1'b0;
    int errors = 0;
    int checks = 0;
    int seed = 99;
    int cycles = 0;
    int cnt = 0;
    int kind = 0;
    int k, r;

    slr_lun_router #(.SELFTEST_CYCLES(st)) slr_lun_router_inst (.mclk(mclk), .rst_b(rst_b),
        .scc_mode(scc_mode), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_lun(cmd_lun),
        .comp_fault(comp_fault), .proc_valid(proc_valid), .proc_opcode(proc_opcode),
        .proc_inquiry(proc_inquiry), .proc_pdt(proc_pdt), .proc_report_luns(proc_report_luns),
        .route_valid(route_valid), .route_bus(route_bus), .route_target(route_target),
        .route_lun(route_lun), .reject_valid(reject_valid), .ready(ready), .fault_led(fault_led));
    slr_host slr_host_inst (.mclk(mclk), .ready(ready), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_lun(cmd_lun));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // 0 none, 1 processor, 2 routed, 3 rejected
    function automatic int exp_kind(logic s, logic [7:0] o, logic [63:0] l);
        if (!s) return 0;
        if (l[63:62] == 2'b00) return (o == slr_pkg::op_inquiry && |l) ? 3 : 1;
        if (l[63:62] == 2'b10) return 2;
        return 3;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk or negedge rst_b) begin
        cnt <= rst_b ? cnt + 1 : 0;
        cycles++;
        if (cycles >= 5000) begin
            errors++;
            end_of_test();
        end
    end
    always @(posedge mclk) begin
        #1 comp_fault = ($random(seed) & 7) == 0;
    end
    // outputs settle by the falling edge; the command taken at the next edge is noted here
    always @(negedge mclk) begin
        if (rst_b) begin
            chk("ready", 8'(cnt >= st), 8'(ready));
            if (!ready) chk("fault_led", 8'h1, 8'(fault_led));
            else if (r_prev) chk("fault_led", 8'(f_prev), 8'(fault_led));
            chk("proc_valid", 8'(kind == 1), 8'(proc_valid));
            chk("route_valid", 8'(kind == 2), 8'(route_valid));
            chk("reject_valid", 8'(kind == 3), 8'(reject_valid));
            if (kind == 1) begin
                chk("proc_opcode", e_op, proc_opcode);
                chk("proc_inquiry", 8'(e_op == slr_pkg::op_inquiry), 8'(proc_inquiry));
                chk("proc_report_luns", 8'(e_op == slr_pkg::op_report_luns),
                    8'(proc_report_luns));
                chk("proc_pdt", 8'(slr_pkg::pdt_controller), 8'(proc_pdt));
            end
            if (kind == 2) begin
                chk("route_bus", 8'(e_lun[55:53]), 8'(route_bus));
                chk("route_target", 8'(e_lun[61:56]), 8'(route_target));
                chk("route_lun", 8'(e_lun[52:48]), 8'(route_lun));
            end
        end
        kind = (cmd_valid && ready && rst_b) ? exp_kind(scc_mode, cmd_opcode, cmd_lun) : 0;
        e_op = cmd_opcode;
        e_lun = cmd_lun;
        f_prev = comp_fault;
        r_prev = ready;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        scc_mode = 1'b1;
        repeat (6) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (st + 2) @(posedge mclk);
        #1;
        slr_host_inst.send(slr_pkg::op_inquiry, 64'h0);
        slr_host_inst.send(slr_pkg::op_report_luns, 64'h0000_FFFF_FFFF_FFFF);
        slr_host_inst.send(slr_pkg::op_inquiry, 64'h0000_0000_0000_0001);
        for (k = 0; k < 4; k++) begin
            lun = {$random(seed), $random(seed)};
            slr_host_inst.send(8'h28, {k[1:0], lun[61:0]});
        end
        slr_host_inst.idle();
        @(posedge mclk);
        #1 scc_mode = 1'b0;
        slr_host_inst.send(slr_pkg::op_inquiry, 64'h0);
        slr_host_inst.idle();
        @(posedge mclk);
        #1 scc_mode = 1'b1;
        repeat (60) begin
            r = $random(seed);
            lun = {$random(seed), $random(seed)};
            op = (r[1:0] == 2'b00) ? slr_pkg::op_inquiry :
                 (r[1:0] == 2'b01) ? slr_pkg::op_report_luns : r[15:8];
            if (r[4:2] == 3'b000) lun = 64'h0;
            slr_host_inst.send(op, lun);
            if (r[5]) begin
                slr_host_inst.idle();
                @(posedge mclk);
                #1;
            end
        end
        slr_host_inst.idle();
        repeat (3) @(posedge mclk);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
